// ### mem_port.sv
// Core external memory and coprocessor bus port
`timescale 1ns/1ps
// Behaviour
// [R01] Unidirectional write bus zero unless selected
// [R02] Write data held through falling edge
// [R03] Exported clock is memory or debug clock
// [R04] Locked output only during atomic swap
// [R05] Controller blocks other masters while locked
// [R06] Size codes byte, halfword, word; 11 reserved
// [R07] Size stable across the memory cycle
// [R08] Memory clock paces everything; wait stretches
// [R09] Drive coprocessor request low, await responses
// [R10] Absent at first edge: abort, undefined trap
// [R11] Present: wait for busy low, complete
// [R12] Bidirectional bus driven only with enable-in low
// [R13] Interrupts sampled per sync select
// [R14] Sample busy every edge while requesting
// [R15] Data output enable gates both output buses
// [R16] Enable-out low throughout write cycle
// [R17] Read from input bus when selected
// [R18] Reserved size code never driven
module mem_port #(
  parameter int unsigned DATA_W = 32
) (
  // Clock and reset
  input  wire logic                  ref_clk_i,
  input  wire logic                  rst_i,
  // Clocking control
  input  wire logic                  wait_stretch_n_i,
  input  wire logic                  debug_mode_i,
  input  wire logic                  debug_clock_i,
  // Core-side memory request and response
  input  wire mem_port_pkg::mem_req_t mem_req_i,
  output logic                       mem_accept_o,
  output mem_port_pkg::mem_rsp_t     mem_rsp_o,
  // Core-side coprocessor request and result
  input  wire logic                  cop_start_i,
  output mem_port_pkg::cop_result_t  cop_result_o,
  // Bus configuration inputs
  input  wire logic                  unidirectional_bus_select_i,
  input  wire logic                  data_output_enable_i,
  input  wire logic                  write_drive_enable_in_n_i,
  // Data buses
  input  wire logic [DATA_W-1:0]     data_in_i,
  input  wire logic [DATA_W-1:0]     data_bidir_i,
  output logic      [DATA_W-1:0]     data_bidir_o,
  output logic                       data_bidir_oe_o,
  output logic      [DATA_W-1:0]     data_out_o,
  // Cycle indications
  output logic      [1:0]            transfer_size_o,
  output logic                       locked_access_o,
  output logic                       write_cycle_enable_out_n_o,
  output logic                       exported_clock_o,
  // Coprocessor handshake
  output logic                       coproc_instruction_n_o,
  input  wire logic                  coproc_absent_i,
  input  wire logic                  coproc_busy_i,
  // Interrupts
  input  wire logic                  interrupt_sync_select_i,
  input  wire logic                  normal_interrupt_request_n_i,
  input  wire logic                  fast_interrupt_request_n_i,
  output logic                       irq_o,
  output logic                       fiq_o
);
  import mem_port_pkg::*;

  // Elaboration check on bus width
  if (DATA_W != 32) begin : g_bad_width
    $error("mem_port supports only a 32-bit data bus");
  end

  // Coprocessor handshake states
  typedef enum logic [1:0] {COP_IDLE, COP_PROBE, COP_BUSY} cop_state_t;

  // Memory cycle registers
  logic              active_reg;       // A memory cycle is in progress
  logic              active_next;
  logic              write_reg;        // Current cycle is a write
  logic              write_next;
  logic [1:0]        size_reg;         // Transfer size of current cycle
  logic [1:0]        size_next;
  logic              lock_reg;         // Locked access indication
  logic              lock_next;
  logic [DATA_W-1:0] wdata_reg;        // Write data being presented
  logic [DATA_W-1:0] wdata_next;
  logic [DATA_W-1:0] dout_reg;         // Unidirectional output bus
  logic [DATA_W-1:0] dout_next;
  logic [DATA_W-1:0] bidir_reg;        // Bidirectional output value
  logic [DATA_W-1:0] bidir_next;
  logic              bidir_oe_reg;     // Bidirectional drive enable
  logic              bidir_oe_next;
  logic              enout_n_reg;      // Write cycle enable output
  logic              enout_n_next;
  logic              accept_reg;       // Request taken this cycle
  logic              accept_next;
  mem_rsp_t          rsp_reg;          // Read response
  mem_rsp_t          rsp_next;
  logic              exported_clock_reg;         // Exported clock
  logic              exported_clock_next;
  // Coprocessor registers
  cop_state_t        cop_reg;
  cop_state_t        cop_next;
  logic              cpi_n_reg;        // Coprocessor request, active low
  logic              cpi_n_next;
  cop_result_t       cop_res_reg;
  cop_result_t       cop_res_next;

  // Size legaliser: never lets the reserved code reach the pins
  function automatic logic [1:0] legal_size(input logic [1:0] size);
    legal_size = (size == SIZE_RESERVED) ? SIZE_WORD : size; // [R18]
  endfunction

  // Clock stretch: a low wait input holds the current cycle
  wire stall       = ~wait_stretch_n_i;                         // [R08]
  wire take_req    = mem_req_i.valid & ~stall;                  // [R08]
  wire cyc_write   = active_reg & write_reg;
  wire cyc_read    = active_reg & ~write_reg;
  // Output gating by bus select and data output enable
  wire uni_drive   = unidirectional_bus_select_i & data_output_enable_i; // [R01] [R15]
  wire bidir_drive = cyc_write & data_output_enable_i & ~write_drive_enable_in_n_i; // [R12]
  // Read source selection
  wire [DATA_W-1:0] read_src = unidirectional_bus_select_i ? data_in_i : data_bidir_i; // [R17]

  // Memory cycle sequencing
  always_comb begin
    active_next = active_reg;
    write_next  = write_reg;
    size_next   = size_reg;
    lock_next   = lock_reg;
    wdata_next  = wdata_reg;
    accept_next = 1'b0;
    if (!stall) begin
      // Cycle ends at an unstretched edge; a new one may follow at once
      active_next = take_req;
      accept_next = take_req;
      if (take_req) begin
        write_next = mem_req_i.write;
        size_next  = legal_size(mem_req_i.size);      // [R06] [R07]
        lock_next  = mem_req_i.locked;                // [R04]
        wdata_next = mem_req_i.wdata;                 // [R02]
      end else begin
        lock_next  = 1'b0;                            // [R04]
      end
    end
  end

  // Data bus drive and read capture
  always_comb begin
    dout_next     = (cyc_write && uni_drive) ? wdata_reg : DATA_RESET; // [R01] [R02] [R15]
    bidir_next    = wdata_reg;                                         // [R02]
    bidir_oe_next = bidir_drive;                                       // [R12] [R15]
    enout_n_next  = ~cyc_write;                                        // [R16]
    rsp_next      = '{valid: 1'b0, rdata: rsp_reg.rdata};
    if (cyc_read && !stall) begin
      rsp_next = '{valid: 1'b1, rdata: read_src};                      // [R17]
    end
  end

  // Exported clock: toggles at the memory rate unless stretched or debugged
  always_comb begin
    if (debug_mode_i) begin
      exported_clock_next = debug_clock_i;                                       // [R03]
    end else if (stall) begin
      exported_clock_next = 1'b0;                                                // [R03]
    end else begin
      exported_clock_next = ~exported_clock_reg;                                           // [R03]
    end
  end

  // Coprocessor handshake
  always_comb begin
    cop_next     = cop_reg;
    cpi_n_next   = cpi_n_reg;
    cop_res_next = '{done: 1'b0, undefined: 1'b0};
    unique case (cop_reg)
      COP_IDLE: begin
        if (cop_start_i) begin
          cop_next   = COP_PROBE;
          cpi_n_next = 1'b0;                                           // [R09]
        end
      end
      COP_PROBE: begin
        if (!stall) begin
          if (coproc_absent_i) begin
            cop_next     = COP_IDLE;                                   // [R10]
            cpi_n_next   = 1'b1;
            cop_res_next = '{done: 1'b0, undefined: 1'b1};             // [R10]
          end else if (!coproc_busy_i) begin
            cop_next     = COP_IDLE;                                   // [R11] [R14]
            cpi_n_next   = 1'b1;
            cop_res_next = '{done: 1'b1, undefined: 1'b0};
          end else begin
            cop_next = COP_BUSY;                                       // [R11]
          end
        end
      end
      COP_BUSY: begin
        if (!stall && !coproc_busy_i) begin
          cop_next     = COP_IDLE;                                     // [R11] [R14]
          cpi_n_next   = 1'b1;
          cop_res_next = '{done: 1'b1, undefined: 1'b0};
        end
      end
      default: begin
        cop_next   = COP_IDLE;
        cpi_n_next = 1'b1;
      end
    endcase
  end

  // Cycle state registers
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      active_reg <= 1'b0;
      write_reg  <= 1'b0;
      size_reg   <= SIZE_RESET;
      lock_reg   <= 1'b0;
      wdata_reg  <= DATA_RESET;
      accept_reg <= 1'b0;
    end else begin
      active_reg <= active_next;
      write_reg  <= write_next;
      size_reg   <= size_next;
      lock_reg   <= lock_next;
      wdata_reg  <= wdata_next;
      accept_reg <= accept_next;
    end
  end

  // Pin output registers
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      dout_reg     <= DATA_RESET;
      bidir_reg    <= DATA_RESET;
      bidir_oe_reg <= 1'b0;
      enout_n_reg  <= 1'b1;
      rsp_reg      <= '0;
      exported_clock_reg     <= 1'b0;
    end else begin
      dout_reg     <= dout_next;
      bidir_reg    <= bidir_next;
      bidir_oe_reg <= bidir_oe_next;
      enout_n_reg  <= enout_n_next;
      rsp_reg      <= rsp_next;
      exported_clock_reg     <= exported_clock_next;
    end
  end

  // Coprocessor registers
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      cop_reg     <= COP_IDLE;
      cpi_n_reg   <= 1'b1;
      cop_res_reg <= '0;
    end else begin
      cop_reg     <= cop_next;
      cpi_n_reg   <= cpi_n_next;
      cop_res_reg <= cop_res_next;
    end
  end

  // Interrupt request sampling
  irq_sampler u_irq (
    .ref_clk_i                    (ref_clk_i),
    .rst_i                        (rst_i),
    .interrupt_sync_select_i      (interrupt_sync_select_i),
    .normal_interrupt_request_n_i (normal_interrupt_request_n_i),
    .fast_interrupt_request_n_i   (fast_interrupt_request_n_i),
    .irq_o                        (irq_o),
    .fiq_o                        (fiq_o)
  );

  // Output connections, all from flip-flops
  assign mem_accept_o               = accept_reg;
  assign mem_rsp_o                  = rsp_reg;
  assign cop_result_o               = cop_res_reg;
  assign data_out_o                 = dout_reg;
  assign data_bidir_o               = bidir_reg;
  assign data_bidir_oe_o            = bidir_oe_reg;
  assign transfer_size_o            = size_reg;
  assign locked_access_o            = lock_reg;
  assign write_cycle_enable_out_n_o = enout_n_reg;
  assign exported_clock_o           = exported_clock_reg;
  assign coproc_instruction_n_o     = cpi_n_reg;
endmodule

// ### mem_port_pkg.sv
// Package: constants and carrier types for the core memory and coprocessor bus port
package mem_port_pkg;

  // Transfer size encodings
  localparam logic [1:0] SIZE_BYTE     = 2'h0;
  localparam logic [1:0] SIZE_HALFWORD = 2'h1;
  localparam logic [1:0] SIZE_WORD     = 2'h2;
  localparam logic [1:0] SIZE_RESERVED = 2'h3;

  // Reset values
  localparam logic [31:0] DATA_RESET  = 32'h0000_0000;
  localparam logic [1:0]  SIZE_RESET  = SIZE_WORD;

  // Interrupt synchroniser depth for asynchronous requests
  localparam int unsigned IRQ_SYNC_STAGES = 2;

  // Request from the core pipeline for one memory cycle
  typedef struct packed {
    logic        valid;   // A memory cycle is requested
    logic        write;   // 1 write, 0 read
    logic        locked;  // Part of an atomic swap
    logic [1:0]  size;    // Requested transfer size
    logic [31:0] wdata;   // Write data
  } mem_req_t;

  // Result of a memory cycle
  typedef struct packed {
    logic        valid;   // Read data captured this cycle
    logic [31:0] rdata;   // Captured read data
  } mem_rsp_t;

  // Coprocessor handshake outcome
  typedef struct packed {
    logic done;       // Coprocessor accepted, handshake complete
    logic undefined;  // No coprocessor: undefined instruction trap
  } cop_result_t;

endpackage

// ### irq_sampler.sv
// Interrupt request sampler: direct or double-flop synchronised per sync select
`timescale 1ns/1ps
module irq_sampler (
  // Clock and reset
  input  wire logic ref_clk_i,
  input  wire logic rst_i,
  // Raw requests and mode
  input  wire logic interrupt_sync_select_i,
  input  wire logic normal_interrupt_request_n_i,
  input  wire logic fast_interrupt_request_n_i,
  // Sampled active-high requests
  output logic      irq_o,
  output logic      fiq_o
);
  import mem_port_pkg::*;

  logic [1:0] meta_reg;   // First synchroniser stage, read only by second
  logic [1:0] sync_reg;   // Second synchroniser stage
  logic [1:0] out_reg;    // Registered result
  wire  [1:0] raw_req = {~fast_interrupt_request_n_i, ~normal_interrupt_request_n_i};
  // Synchronous requests skip the synchroniser
  wire  [1:0] sel_req = interrupt_sync_select_i ? raw_req : sync_reg; // [R13]

  // Synchroniser and output registers
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      meta_reg <= 2'h0;
      sync_reg <= 2'h0;
      out_reg  <= 2'h0;
    end else begin
      meta_reg <= raw_req;
      sync_reg <= meta_reg;
      out_reg  <= sel_req;
    end
  end

  assign irq_o = out_reg[0];
  assign fiq_o = out_reg[1];
endmodule

// ### mem_port_props.sv
// Assertion checker for the memory and coprocessor bus port
`timescale 1ns/1ps
module mem_port_props #(
  parameter int unsigned DATA_W = 32
) (
  // Clock and reset
  input wire logic                       ref_clk_i,
  input wire logic                       rst_i,
  // Watched inputs
  input wire logic                       wait_stretch_n_i,
  input wire mem_port_pkg::mem_req_t     mem_req_i,
  input wire logic                       unidirectional_bus_select_i,
  input wire logic                       data_output_enable_i,
  input wire logic                       write_drive_enable_in_n_i,
  input wire logic                       coproc_absent_i,
  input wire logic                       coproc_busy_i,
  // Watched outputs
  input wire logic                       mem_accept_o,
  input wire mem_port_pkg::cop_result_t  cop_result_o,
  input wire logic                       data_bidir_oe_o,
  input wire logic [DATA_W-1:0]          data_out_o,
  input wire logic [1:0]                 transfer_size_o,
  input wire logic                       locked_access_o,
  input wire logic                       write_cycle_enable_out_n_o,
  input wire logic                       coproc_instruction_n_o
);
  import mem_port_pkg::*;
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (rst_i);
  // First probe edge of a handshake finds no coprocessor
  sequence absent_probe;
    $fell(coproc_instruction_n_o) && coproc_absent_i && wait_stretch_n_i;
  endsequence
  // Handshake edge where only busy decides the outcome
  sequence live_probe;
    !coproc_instruction_n_o && wait_stretch_n_i
      && !($fell(coproc_instruction_n_o) && coproc_absent_i);
  endsequence
  chk_size_legal: assert property (transfer_size_o != SIZE_RESERVED)
    else $error("reserved size code driven");
  chk_size_take: assert property (mem_accept_o |-> transfer_size_o ==
    (($past(mem_req_i.size) == SIZE_RESERVED) ? SIZE_WORD : $past(mem_req_i.size)))
    else $error("size does not follow request");
  chk_lock_take: assert property (mem_accept_o |-> locked_access_o == $past(mem_req_i.locked))
    else $error("lock does not follow request");
  chk_lock_idle: assert property (!mem_req_i.valid && wait_stretch_n_i |=> !locked_access_o)
    else $error("lock held with no cycle");
  chk_accept_take: assert property (mem_req_i.valid && wait_stretch_n_i |=> mem_accept_o)
    else $error("request not taken");
  chk_stall_holds: assert property (!wait_stretch_n_i |=> !mem_accept_o)
    else $error("request taken while stalled");
  chk_enout_cause: assert property ($fell(write_cycle_enable_out_n_o) |-> $past(mem_accept_o))
    else $error("enable out low without a cycle");
  chk_dout_unsel: assert property (!unidirectional_bus_select_i [*3] |=> data_out_o == '0)
    else $error("output bus not zero when unselected");
  chk_dout_gated: assert property (!data_output_enable_i [*3] |=>
    data_out_o == '0 && !data_bidir_oe_o)
    else $error("data driven with output enable low");
  chk_oe_enin: assert property (write_drive_enable_in_n_i [*3] |=> !data_bidir_oe_o)
    else $error("bus driven with enable in high");
  chk_cop_abort: assert property (absent_probe |=>
    cop_result_o.undefined && !cop_result_o.done && coproc_instruction_n_o)
    else $error("absent coprocessor not trapped");
  chk_cop_done: assert property (live_probe ##0 !coproc_busy_i |=>
    cop_result_o.done && coproc_instruction_n_o)
    else $error("handshake not completed");
  chk_cop_wait: assert property (live_probe ##0 coproc_busy_i |=>
    !coproc_instruction_n_o && !cop_result_o.done)
    else $error("busy coprocessor not waited for");
endmodule
bind mem_port mem_port_props #(.DATA_W(DATA_W)) u_props (.*);

// ### far_side_model.sv
// Memory and coprocessor model on the far side of the port
`timescale 1ns/1ps
module far_side_model (
  // Clock and handshake from the port
  input  wire logic        ref_clk_i,
  input  wire logic        coproc_instruction_n_i,
  input  wire logic        mem_accept_i,
  // Scenario knobs
  input  wire logic        absent_mode_i,
  input  wire logic [3:0]  busy_cycles_i,
  input  wire logic [31:0] rd_word_i,
  // Responses
  output logic             coproc_absent_o,
  output logic             coproc_busy_o,
  output logic [31:0]      data_in_o,
  output logic [31:0]      data_bidir_o
);
  logic [3:0] probe_cnt_reg;  // Edges seen with a request pending
  // Sole master: no other grant ever competes while the lock is up
  // Count handshake edges so busy releases after a set delay
  always_ff @(posedge ref_clk_i) begin
    probe_cnt_reg <= coproc_instruction_n_i ? 4'h0 : probe_cnt_reg + 4'h1;
  end
  assign coproc_absent_o = !coproc_instruction_n_i && absent_mode_i;
  assign coproc_busy_o = coproc_instruction_n_i || (probe_cnt_reg < busy_cycles_i);
  // Read data valid only before the sampling edge; inverted otherwise
  assign data_in_o = mem_accept_i ? rd_word_i : ~rd_word_i;
  assign data_bidir_o = mem_accept_i ? rd_word_i ^ 32'h0f0f_0f0f : ~rd_word_i;
endmodule

// ### mem_port_tb.sv
// Self-checking bench for the memory and coprocessor bus port
`timescale 1ns/1ps
module mem_port_tb;
  import mem_port_pkg::*;
  // Design pins, named as the ports
  logic        ref_clk_i, rst_i, wait_stretch_n_i, debug_mode_i, debug_clock_i, cop_start_i;
  logic        unidirectional_bus_select_i, data_output_enable_i, write_drive_enable_in_n_i;
  logic        interrupt_sync_select_i, normal_interrupt_request_n_i, fast_interrupt_request_n_i;
  logic        mem_accept_o, data_bidir_oe_o, locked_access_o, write_cycle_enable_out_n_o;
  logic        exported_clock_o, coproc_instruction_n_o, coproc_absent_i, coproc_busy_i;
  logic        irq_o, fiq_o, absent_mode, v, pv;
  logic [1:0]  transfer_size_o;
  logic [3:0]  busy_cyc;
  logic [31:0] data_in_i, data_bidir_i, data_bidir_o, data_out_o, rd_word, r;
  mem_req_t    mem_req_i;
  mem_rsp_t    mem_rsp_o;
  cop_result_t cop_result_o;
  int          error_cnt, n_tests, cyc, i;
  mem_port uut (.*);
  far_side_model u_far (.ref_clk_i(ref_clk_i), .coproc_instruction_n_i(coproc_instruction_n_o),
    .mem_accept_i(mem_accept_o), .absent_mode_i(absent_mode), .busy_cycles_i(busy_cyc),
    .rd_word_i(rd_word), .coproc_absent_o(coproc_absent_i), .coproc_busy_o(coproc_busy_i),
    .data_in_o(data_in_i), .data_bidir_o(data_bidir_i));
  // Compare and count
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      error_cnt++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  // One memory cycle with random bus gating
  task automatic mem_op(input logic w, input logic lk, input logic [1:0] sz, input logic [31:0] d);
    @(posedge ref_clk_i);
    mem_req_i <= '{valid: 1'b1, write: w, locked: lk, size: sz, wdata: d};
    rd_word <= $urandom;
    unidirectional_bus_select_i <= $urandom;
    data_output_enable_i <= $urandom;
    write_drive_enable_in_n_i <= $urandom;
    @(posedge ref_clk_i);
    mem_req_i.valid <= 1'b0;
    #1;
    check(mem_accept_o, 1'b1);
    check(transfer_size_o, (sz == SIZE_RESERVED) ? SIZE_WORD : sz);
    check(locked_access_o, lk);
    @(posedge ref_clk_i);
    #1;
    if (w) begin
      check(data_out_o, (unidirectional_bus_select_i && data_output_enable_i) ? d : '0);
      check(write_cycle_enable_out_n_o, 1'b0);
      check(data_bidir_o, d);
      check(data_bidir_oe_o, data_output_enable_i && !write_drive_enable_in_n_i);
    end else begin
      check(mem_rsp_o.valid, 1'b1);
      check(mem_rsp_o.rdata, unidirectional_bus_select_i ? rd_word : rd_word ^ 32'h0f0f_0f0f);
    end
  endtask
  // Coprocessor handshake, outcome and latency
  task automatic cop_op(input logic ab, input logic [3:0] bc);
    int n;
    @(posedge ref_clk_i);
    absent_mode <= ab;
    busy_cyc <= bc;
    cop_start_i <= 1'b1;
    @(posedge ref_clk_i);
    cop_start_i <= 1'b0;
    #1;
    check(coproc_instruction_n_o, 1'b0);
    for (n = 1; n < 20; n++) begin
      @(posedge ref_clk_i);
      #1;
      if (cop_result_o.done || cop_result_o.undefined) break;
    end
    check(n, ab ? 1 : 1 + bc);
    check(cop_result_o, {!ab, ab});
    check(coproc_instruction_n_o, 1'b1);
  endtask
  // Interrupt latency in each sampling mode
  task automatic irq_op(input logic s, input logic fast);
    int n;
    @(posedge ref_clk_i);
    interrupt_sync_select_i <= s;
    repeat (4) @(posedge ref_clk_i);
    if (fast) fast_interrupt_request_n_i <= 1'b0;
    else normal_interrupt_request_n_i <= 1'b0;
    for (n = 1; n < 8; n++) begin
      @(posedge ref_clk_i);
      #1;
      if (fast ? fiq_o : irq_o) break;
    end
    check(n, s ? 1 : 3);
    @(posedge ref_clk_i);
    fast_interrupt_request_n_i <= 1'b1;
    normal_interrupt_request_n_i <= 1'b1;
  endtask
  // Free-running clock
  initial begin
    ref_clk_i = 1'b0;
    forever #5 ref_clk_i = ~ref_clk_i;
  end
  // Hang guard
  always @(posedge ref_clk_i) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      error_cnt++;
      tally_and_finish();
    end
  end
  initial begin
    error_cnt = 0;
    n_tests = 0;
    cyc = 0;
    rst_i = 1'b1;
    {wait_stretch_n_i, normal_interrupt_request_n_i, fast_interrupt_request_n_i} = 3'h7;
    {debug_mode_i, debug_clock_i, cop_start_i, absent_mode, v, pv} = 6'h0;
    {unidirectional_bus_select_i, data_output_enable_i, write_drive_enable_in_n_i} = 3'h6;
    interrupt_sync_select_i = 1'b1;
    busy_cyc = 4'h0;
    rd_word = '0;
    mem_req_i = '0;
    void'($urandom(18));
    repeat (10) @(posedge ref_clk_i);
    rst_i <= 1'b0;
    // Every size code both ways, then random cycles
    for (i = 0; i < 8; i++) mem_op(i[0], i[1], i[2:1], 32'h8421_1248 << i);
    for (i = 0; i < 40; i++) begin
      r = $urandom;
      mem_op(r[0], r[1], r[3:2], $urandom);
    end
    $display("memory cycles done");
    // Stalled request is not taken and clock out holds low
    @(posedge ref_clk_i);
    wait_stretch_n_i <= 1'b0;
    mem_req_i.valid <= 1'b1;
    repeat (3) begin
      @(posedge ref_clk_i);
      #1;
      check(mem_accept_o, 1'b0);
      check(exported_clock_o, 1'b0);
    end
    @(posedge ref_clk_i);
    wait_stretch_n_i <= 1'b1;
    mem_req_i.valid <= 1'b0;
    $display("stall done");
    cop_op(1'b1, 4'h2);
    cop_op(1'b0, 4'h0);
    cop_op(1'b0, 4'h3);
    cop_op(1'b0, 4'(1 + $urandom % 6));
    $display("coprocessor done");
    for (i = 0; i < 4; i++) irq_op(i[0], i[1]);
    $display("interrupts done");
    // Exported clock follows the debug clock one cycle late
    @(posedge ref_clk_i);
    debug_mode_i <= 1'b1;
    for (i = 0; i < 12; i++) begin
      @(posedge ref_clk_i);
      debug_clock_i <= v;
      @(negedge ref_clk_i);
      if (i > 1) check(exported_clock_o, pv);
      pv = v;
      v = $urandom;
    end
    @(posedge ref_clk_i);
    debug_mode_i <= 1'b0;
    repeat (3) @(negedge ref_clk_i);
    for (i = 0; i < 4; i++) begin
      pv = exported_clock_o;
      @(negedge ref_clk_i);
      check(exported_clock_o, !pv);
    end
    $display("clock export done");
    tally_and_finish();
  end
endmodule
